// ==== hw/fcmb_pkg.sv ====
// Purpose: constants shared by the field command mailbox
// Assumes: 32-bit apb, byte addresses, four hart channels
// Notes:   record n sits at rec_base + 8*n, two words per record
package fcmb_pkg;

  // apb map
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STAT_OFS    = 12'h004;
  localparam logic [11:0] VSEL_OFS    = 12'h008;
  localparam logic [11:0] REV_OFS     = 12'h00c;
  localparam logic [11:0] IN_OFS      = 12'h020;
  localparam logic [11:0] REC_BASE    = 12'h400;

  // record numbers
  localparam logic [7:0]  REQ_REC_LO  = 8'h50;
  localparam logic [7:0]  REQ_REC_HI  = 8'h56;
  localparam logic [7:0]  VAR_REC     = 8'h79;
  localparam logic [7:0]  MAP_REC     = 8'h8c;

  // request word 0 layout
  localparam int          SHC_BIT     = 8;
  localparam int          BURST_BIT   = 9;

  // processing status codes
  localparam logic [1:0]  PS_IDLE     = 2'h0;
  localparam logic [1:0]  PS_BUSY     = 2'h1;
  localparam logic [1:0]  PS_OK       = 2'h2;
  localparam logic [1:0]  PS_ERR      = 2'h3;

  // codes the block writes into a rejected response
  localparam logic [7:0]  ERR_INTERP  = 8'h01;
  localparam logic [7:0]  ERR_RESERVED = 8'h02;

  // polling commands and revisions
  localparam logic [7:0]  CMD_VAR_OLD = 8'h03;
  localparam logic [7:0]  CMD_VAR_NEW = 8'h09;
  localparam logic [7:0]  REV_NEW     = 8'h07;
  localparam logic [7:0]  REV_RESET   = 8'h05;

  // quality codes, status2 mask and response codes
  localparam logic [7:0]  QC_OK       = 8'h80;
  localparam logic [7:0]  QC_UNC      = 8'h78;
  localparam logic [7:0]  QC_MANUAL   = 8'h78;
  localparam logic [7:0]  QC_POOR     = 8'h68;
  localparam logic [7:0]  QC_BAD      = 8'h28;
  localparam logic [7:0]  QC_MORE     = 8'h88;
  localparam logic [7:0]  QC_UPD      = 8'h84;
  localparam logic [7:0]  QC_ACC      = 8'h24;
  localparam logic [7:0]  QC_COMM     = 8'h23;
  localparam logic [7:0]  QC_INIT     = 8'h37;
  localparam logic [7:0]  QC_SYS      = 8'h00;
  localparam logic [7:0]  ST2_UNC_MASK = 8'h17;
  localparam logic [7:0]  RC_UPDATE   = 8'h08;
  localparam logic [7:0]  RC_ACCESS   = 8'h10;

  // input area
  localparam logic [4:0]  IN_AREA_BYTES = 5'h14;

  // timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          TICK_NS       = 1000000;
  localparam int          RES_TIME_MS   = 2000;
  localparam logic [10:0] RES_TICKS     = 11'(RES_TIME_MS);

  typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} fcmb_state_type;

endpackage

// ==== hw/fcmb_top.sv ====
// Purpose: four-channel hart request/response mailbox with polling
// Assumes: field link logic runs on pclk, one job in flight at a time
// Notes:   apb answers with zero wait states
// Summary of operation
// R1 - request on even record, response on next
// R2 - bad request flagged, still readable back
// R3 - client reads response before next request
// R4 - newer request overwrites pending response
// R5 - response carries processing status field
// R6 - client reads whole response record
// R7 - accepted request locks record, writes busy
// R8 - lock released when command finishes
// R9 - flagged command reserves link two seconds
// R10 - each flagged command restarts reservation
// R11 - unflagged command or timeout ends reservation
// R12 - poll variables, command by revision
// R13 - variable record always readable
// R14 - mapping record selects input variables
// R15 - mapped input area is twenty bytes
// R16 - value word then quality byte
// R17 - quality byte field layout
// R18 - old revisions use status bytes only
// R19 - old revisions default quality 80
// R20 - listed status bits give quality 78
// R21 - error and response codes give quality
// R22 - quality starts at 37 after reset
// R23 - one client per channel
// R24 - burst commands refused with error, never forwarded
// R25 - reservation timed by prescaled tick counter
`timescale 1ns/1ps
`default_nettype none
module fcmb_top #(
  parameter int TICK_CYCLES = fcmb_pkg::TICK_NS / fcmb_pkg::CLK_PERIOD_NS
) (
  input  wire logic                      pclk,              // bus clock
  input  wire logic                      presetn,           // async reset
  input  wire logic                      psel,              // apb select
  input  wire logic                      penable,           // apb enable
  input  wire logic                      pwrite,            // apb write
  input  wire logic [fcmb_pkg::ADDR_W-1:0] paddr,           // byte address
  input  wire logic [31:0]               pwdata,            // write data
  output logic      [31:0]               prdata,            // read data
  output logic                           pready,            // apb ready
  output logic                           pslverr,           // busy/unmapped
  output logic                           hart_req_valid,    // job offered
  input  wire logic                      hart_req_ready,    // job taken
  output logic      [1:0]                hart_req_ch,       // channel
  output logic      [7:0]                hart_req_cmd,      // command
  output logic      [31:0]               hart_req_data,     // payload
  input  wire logic                      hart_rsp_valid,    // answer pulse
  input  wire logic [7:0]                hart_rsp_code,     // response code
  input  wire logic [7:0]                hart_rsp_status1,  // status 1
  input  wire logic [7:0]                hart_rsp_status2,  // status 2
  input  wire logic [7:0]                hart_rsp_dvs,      // var status
  input  wire logic [31:0]               hart_rsp_data,     // value
  input  wire logic                      hart_rsp_comm_err, // no answer
  output logic      [4:0]                in_area_bytes      // input size
);
  import fcmb_pkg::*;

  // quality encoding of one polled answer
  function automatic logic [7:0] fcmb_quality(
    input logic       rev_new,
    input logic       comm_err,
    input logic [7:0] rc,
    input logic [7:0] st1,
    input logic [7:0] st2,
    input logic [7:0] dvs);
    logic [7:0] q;
    q = QC_OK;
    // R21 error codes first
    if (comm_err || st1[7])
      q = QC_COMM;
    else if (rc == RC_UPDATE)
      q = QC_UPD;
    else if (rc == RC_ACCESS)
      q = QC_ACC;
    // R18 status bytes only
    else if (!rev_new) begin
      // R20 uncertain bits, R19 others stay 80
      q = ((st2 & ST2_UNC_MASK) != 8'h00) ? QC_UNC : QC_OK;
    end else begin
      // R17 quality, sub-status, limits
      case (dvs[7:6])
        2'b11:   q = dvs[3] ? QC_MORE : QC_OK;
        2'b10:   q = QC_MANUAL;
        2'b01:   q = QC_POOR;
        default: q = QC_BAD;
      endcase
      q[1:0] = dvs[5:4];
    end
    return q;
  endfunction

  fcmb_state_type state;
  logic        hart_en;
  logic [3:0]  vsel;
  logic [31:0] rev_reg;
  logic [31:0] map_reg;
  logic [31:0] req_w0   [4];
  logic [31:0] req_data [4];
  logic [31:0] rsp_stat [4];
  logic [31:0] rsp_data [4];
  logic [31:0] var_val  [16];
  logic [7:0]  var_qc   [16];
  logic [3:0]  lock;
  logic [3:0]  job_pend;
  logic [3:0]  rsp_unread;
  logic [1:0]  cur_ch;
  logic        cur_poll;
  logic [3:0]  poll_idx;
  logic [7:0]  cur_cmd;
  logic [31:0] cur_data;
  logic        res_active;
  logic [1:0]  res_ch;
  logic [10:0] res_ms;
  logic [15:0] tick_cnt;

  // apb decode
  wire         acc_wr   = psel && penable && pwrite;
  wire         acc_rd   = psel && penable && !pwrite;
  wire         setup    = psel && !penable;
  wire  [11:0] rec_off  = paddr - REC_BASE;
  wire  [7:0]  rec_num  = rec_off[10:3];
  wire         rec_word = paddr[2];
  wire         rec_in   = (paddr >= REC_BASE) && !rec_off[11];
  wire  [7:0]  rec_rel  = rec_num - REQ_REC_LO;
  wire  [1:0]  rec_ch   = rec_rel[2:1];
  // R1 fixed record pairs per channel
  wire         chan_rec = rec_in && (rec_num >= REQ_REC_LO)
                          && (rec_num <= REQ_REC_HI + 8'h01);
  wire         hit_req  = chan_rec && !rec_num[0];
  wire         hit_rsp  = chan_rec && rec_num[0];
  wire         hit_var  = rec_in && (rec_num == VAR_REC);
  wire         hit_map  = rec_in && (rec_num == MAP_REC);
  wire         hit_ctrl = (paddr == CTRL_OFS);
  wire         hit_stat = (paddr == STAT_OFS);
  wire         hit_vsel = (paddr == VSEL_OFS);
  wire         hit_rev  = (paddr == REV_OFS);
  wire  [11:0] in_off   = paddr - IN_OFS;
  wire  [2:0]  in_idx   = in_off[4:2];
  wire         hit_in   = (paddr >= IN_OFS) && (in_off < 12'h014);
  wire         wr_ok    = hit_ctrl || hit_vsel || hit_rev || hit_map
                          || hit_req;
  wire         rd_ok    = wr_ok || hit_stat || hit_in || hit_rsp
                          || hit_var;
  // R7 busy answer on locked request
  wire         busy_wr  = hit_req && lock[rec_ch];
  wire         err_now  = pwrite ? (!wr_ok || busy_wr) : !rd_ok;
  wire         req_wr   = acc_wr && hit_req && !lock[rec_ch];
  wire         accept   = req_wr && !rec_word;

  // R14 mapping slots, R16 value then quality
  logic [31:0] slot_val [4];
  logic [7:0]  slot_qc  [4];
  logic [3:0]  slot_en;
  for (genvar k = 0; k < 4; k++) begin : g_slot
    wire [7:0] m   = map_reg[8*k +: 8];
    wire [3:0] idx = m[3:0];
    assign slot_en[k]  = m[7];
    assign slot_val[k] = m[7] ? var_val[idx] : 32'h0;
    assign slot_qc[k]  = m[7] ? var_qc[idx] : QC_SYS;
  end
  // R15 twenty extra bytes when any slot is mapped, none otherwise
  assign in_area_bytes = (slot_en != 4'h0) ? IN_AREA_BYTES : 5'h00;

  wire  [31:0] in_word  = (in_idx < 3'h4) ? slot_val[in_idx[1:0]]
                          : {slot_qc[3], slot_qc[2], slot_qc[1], slot_qc[0]};
  wire  [31:0] stat_word = {20'h0, rsp_unread, lock, 1'b0, res_active,
                            res_ch};
  // R2 request readback, R13 variables any time
  wire  [31:0] rd_data  =
      hit_ctrl ? {31'h0, hart_en} :
      hit_stat ? stat_word :
      hit_vsel ? {28'h0, vsel} :
      hit_rev  ? rev_reg :
      hit_in   ? in_word :
      hit_req  ? (rec_word ? req_data[rec_ch] : req_w0[rec_ch]) :
      hit_rsp  ? (rec_word ? rsp_data[rec_ch] : rsp_stat[rec_ch]) :
      hit_var  ? (rec_word ? {24'h0, var_qc[vsel]} : var_val[vsel]) :
      hit_map  ? map_reg : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_now;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup && !pwrite)
      prdata <= rd_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hart_en <= 1'b0;
      vsel    <= 4'h0;
      rev_reg <= {4{REV_RESET}};
      map_reg <= 32'h0;
    end else if (acc_wr) begin
      if (hit_ctrl)
        hart_en <= pwdata[0];
      if (hit_vsel)
        vsel <= pwdata[3:0];
      if (hit_rev)
        rev_reg <= pwdata;
      if (hit_map)
        map_reg <= pwdata;
    end
  end

  // job selection
  wire  [1:0]  pick      = job_pend[0] ? 2'd0 : job_pend[1] ? 2'd1 :
                           job_pend[2] ? 2'd2 : 2'd3;
  wire         take_ext  = (state == S_IDLE) && (job_pend != 4'h0);
  wire         ext_burst = req_w0[pick][BURST_BIT];
  wire         ext_block = res_active && (pick != res_ch);
  // R24 burst never forwarded, R9 others refused
  wire         ext_rej   = take_ext && (ext_burst || ext_block);
  wire         ext_issue = take_ext && !ext_rej;
  wire         ext_shc   = req_w0[pick][SHC_BIT];
  // R9 no polling while reserved
  wire         poll_go   = (state == S_IDLE) && (job_pend == 4'h0)
                           && hart_en && !res_active;
  wire  [1:0]  poll_ch   = poll_idx[3:2];
  wire  [7:0]  poll_rev  = rev_reg[8*poll_ch +: 8];
  // R12 command by revision
  wire  [7:0]  poll_cmd  = (poll_rev >= REV_NEW) ? CMD_VAR_NEW
                                                 : CMD_VAR_OLD;
  wire         rsp_done  = (state == S_WAIT) && hart_rsp_valid;
  wire         ext_done  = rsp_done && !cur_poll;
  wire         finish    = ext_rej || ext_done;
  wire  [1:0]  fin_ch    = ext_rej ? pick : cur_ch;
  wire         rsp_bad   = hart_rsp_comm_err || hart_rsp_status1[7];
  wire  [7:0]  fin_code  = !ext_rej ? hart_rsp_code :
                           ext_burst ? ERR_INTERP : ERR_RESERVED;
  // R5 status in every response
  wire  [1:0]  fin_ps    = (ext_rej || rsp_bad) ? PS_ERR : PS_OK;
  wire         rsp_read  = acc_rd && hit_rsp && !rec_word;

  assign hart_req_valid = (state == S_REQ);
  assign hart_req_ch    = cur_ch;
  assign hart_req_cmd   = cur_cmd;
  assign hart_req_data  = cur_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= S_IDLE;
      cur_ch   <= 2'd0;
      cur_poll <= 1'b0;
      cur_cmd  <= 8'h00;
      cur_data <= 32'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (ext_issue || poll_go) begin
            state    <= S_REQ;
            cur_ch   <= ext_issue ? pick : poll_ch;
            cur_poll <= !ext_issue;
            cur_cmd  <= ext_issue ? req_w0[pick][7:0] : poll_cmd;
            cur_data <= ext_issue ? req_data[pick]
                                  : {30'h0, poll_idx[1:0]};
          end
        end
        S_REQ:   if (hart_req_ready) state <= S_WAIT;
        S_WAIT:  if (hart_rsp_valid) state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // mailbox per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock       <= 4'h0;
      job_pend   <= 4'h0;
      rsp_unread <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        req_w0[i]   <= 32'h0;
        req_data[i] <= 32'h0;
        rsp_stat[i] <= 32'h0;
        rsp_data[i] <= 32'h0;
      end
    end else begin
      // R3 unread marker, set wins over read
      if (rsp_read)
        rsp_unread[rec_ch] <= 1'b0;
      if (req_wr && rec_word)
        req_data[rec_ch] <= pwdata;
      if (take_ext)
        job_pend[pick] <= 1'b0;
      if (finish) begin
        // R8 unlock on completion
        lock[fin_ch]       <= 1'b0;
        rsp_unread[fin_ch] <= 1'b1;
        rsp_stat[fin_ch]   <= {hart_rsp_status1, hart_rsp_status2,
                               fin_code, 6'h0, fin_ps};
        rsp_data[fin_ch]   <= ext_rej ? 32'h0 : hart_rsp_data;
      end
      if (accept) begin
        // R7 store and lock, R4 old response dropped
        req_w0[rec_ch]   <= pwdata;
        lock[rec_ch]     <= 1'b1;
        job_pend[rec_ch] <= 1'b1;
        rsp_stat[rec_ch] <= {24'h0, 6'h0, PS_BUSY};
      end
    end
  end

  // polled variables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_idx <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        var_val[i] <= 32'h0;
        // R22 startup quality
        var_qc[i]  <= QC_INIT;
      end
    end else if (rsp_done && cur_poll) begin
      var_val[poll_idx] <= hart_rsp_data;
      var_qc[poll_idx]  <= fcmb_quality(rev_reg[8*cur_ch +: 8] >= REV_NEW,
                             hart_rsp_comm_err, hart_rsp_code,
                             hart_rsp_status1, hart_rsp_status2,
                             hart_rsp_dvs);
      poll_idx <= poll_idx + 4'h1;
    end
  end

  // R25 millisecond tick for the reservation
  wire tick = (tick_cnt == 16'(TICK_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 16'h0;
    else
      tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_active <= 1'b0;
      res_ch     <= 2'd0;
      res_ms     <= 11'h0;
    end else if (ext_issue && ext_shc) begin
      // R9 reserve, R10 restart window
      res_active <= 1'b1;
      res_ch     <= pick;
      res_ms     <= RES_TICKS;
    end else if (ext_issue && res_active) begin
      // R11 unflagged command ends it
      res_active <= 1'b0;
      res_ms     <= 11'h0;
    end else if (res_active && tick) begin
      // R11 timeout ends it
      res_ms <= res_ms - 11'h1;
      if (res_ms == 11'h1)
        res_active <= 1'b0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOCK_ON_ACCEPT: assert property ( // R7
    accept |=> lock[$past(rec_ch)] && job_pend[$past(rec_ch)])
    else $error("accepted request did not lock its record");
  AST_BUSY_ANSWER: assert property ( // R7
    acc_wr && hit_req && lock[rec_ch] |-> pslverr ##1
    req_w0[$past(rec_ch)] == $past(req_w0[rec_ch]))
    else $error("write to locked request not refused");
  AST_UNLOCK_DONE: assert property ( // R8
    finish && !accept |=> !lock[$past(fin_ch)])
    else $error("lock not released on completion");
  AST_PS_BUSY: assert property ( // R5
    accept |=> rsp_stat[$past(rec_ch)][1:0] == PS_BUSY)
    else $error("response status not busy after accept");
  AST_RESERVE_SET: assert property ( // R9
    ext_issue && ext_shc |=> res_active && res_ch == $past(pick)
    && res_ms == RES_TICKS)
    else $error("flagged command did not reserve link");
  AST_RESERVE_EXCL: assert property ( // R9
    res_active && hart_req_valid |-> !cur_poll && hart_req_ch == res_ch)
    else $error("other traffic while link reserved");
  AST_RESERVE_END: assert property ( // R11
    res_active && tick && res_ms == 11'h1 && !ext_issue |=> !res_active)
    else $error("reservation outlived its window");
  AST_POLL_CMD: assert property ( // R12
    hart_req_valid && cur_poll |-> hart_req_cmd ==
    ((rev_reg[8*cur_ch +: 8] >= REV_NEW) ? CMD_VAR_NEW : CMD_VAR_OLD))
    else $error("poll command does not match revision");
  AST_NO_BURST: assert property ( // R24
    take_ext && ext_burst |=> state == S_IDLE && !lock[$past(pick)]
    && rsp_stat[$past(pick)][1:0] == PS_ERR)
    else $error("burst command not refused");
  AST_IN_AREA: assert property ( // R15
    in_area_bytes == ((map_reg[7] || map_reg[15] || map_reg[23]
    || map_reg[31]) ? 5'h14 : 5'h00))
    else $error("input area size wrong");

  COV_SHC: cover property (ext_issue && ext_shc ##[1:20] ext_done);
  COV_BUSY: cover property (acc_wr && busy_wr);
  COV_POLL: cover property (rsp_done && cur_poll);
  COV_REJECT: cover property (ext_rej && ext_block);

endmodule
`default_nettype wire

// ==== testbench/fcmb_link_model.sv ====
// Purpose: field-link responder for the mailbox bench
// Assumes: one job at a time, answer pulse cfg_wait+1 cycles after the job is taken
// Notes:   reply lines show inverted data outside the answer pulse
`timescale 1ns/1ps
`default_nettype none
module fcmb_link_model (
  input  wire logic        pclk,      // clock
  input  wire logic        presetn,   // async reset
  input  wire logic        req_valid, // job offered
  output logic             req_ready, // job taken
  input  wire logic [1:0]  req_ch,    // job channel
  input  wire logic [31:0] req_data,  // job payload
  input  wire logic [64:0] cfg_rsp,   // {err,code,st1,st2,dvs,data}
  input  wire logic [3:0]  cfg_wait,  // answer delay
  output logic             rsp_valid, // answer pulse
  output logic [64:0]      rsp,       // answer fields
  output logic [7:0]       hits       // jobs for ch0 var0
);
  logic        busy;
  logic [3:0]  cnt;
  logic [64:0] held;
  assign req_ready = !busy;
  // released lines never keep the last answer
  assign rsp = rsp_valid ? held : ~held;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      held      <= '0;
      rsp_valid <= 1'b0;
      hits      <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (req_valid && req_ready) begin
        busy <= 1'b1;
        cnt  <= cfg_wait;
        if (req_ch == 2'h0 && req_data[1:0] == 2'h0) begin
          hits <= hits + 8'h01;
        end
      end else if (busy && cnt == 4'h0) begin
        busy      <= 1'b0;
        rsp_valid <= 1'b1;
        held      <= cfg_rsp;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/fcmb_top_tb_top.sv ====
// Purpose: self-checking bench for the field command mailbox
// Assumes: reservation shortened by TICK_CYCLES of 4
// Notes:   apb results compared from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module fcmb_top_tb_top;
  import fcmb_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, seed = 32'd46, d, xp = 0;
  wire  [31:0] prdata, hdat;
  wire         pready, pslverr, hv, hr, rv;
  wire  [1:0]  hch;
  wire  [7:0]  hcmd, hits;
  wire  [64:0] rsp;
  wire  [4:0]  iab;
  logic [64:0] cfg = 0;
  logic [3:0]  cw = 0;
  logic [10:0] xj = 0;
  logic [7:0]  h;
  logic        no_fwd = 0, pol = 0;
  logic [65:0] q[$];
  int          error_cnt = 0, n_tests = 0;
  // {comm error, code, status2, quality}
  logic [31:0] qtab [5] = '{32'h00004080, 32'h00000178, 32'h00080084,
                            32'h00100024, 32'h01000023};

  fcmb_top #(.TICK_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hart_req_valid(hv),
    .hart_req_ready(hr), .hart_req_ch(hch), .hart_req_cmd(hcmd),
    .hart_req_data(hdat), .hart_rsp_valid(rv),
    .hart_rsp_code(rsp[63:56]), .hart_rsp_status1(rsp[55:48]),
    .hart_rsp_status2(rsp[47:40]), .hart_rsp_dvs(rsp[39:32]),
    .hart_rsp_data(rsp[31:0]), .hart_rsp_comm_err(rsp[64]),
    .in_area_bytes(iab));

  fcmb_link_model link (
    .pclk(pclk), .presetn(presetn), .req_valid(hv), .req_ready(hr),
    .req_ch(hch), .req_data(hdat), .cfg_rsp(cfg), .cfg_wait(cw),
    .rsp_valid(rv), .rsp(rsp), .hits(hits));

  always #20 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] ra(int rec, int w);
    return REC_BASE + 12'(rec * 8 + w * 4);
  endfunction

  task automatic fail(string s);
    error_cnt++;
    $display("FAIL %0t %s", $time, s);
  endtask

  task automatic final_report();
    $display("checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // bench is the only client of every channel
  task automatic acc(logic w, logic [11:0] a, logic [31:0] dd,
                     logic [32:0] ev, logic [32:0] em);
    q.push_back({ev, em});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] dd, logic e = 0);
    acc(1'b1, a, dd, {e, 32'h0}, {1'b1, 32'h0});
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] v, logic [31:0] m,
                    logic e = 0);
    acc(1'b0, a, 32'h0, {e, v}, {1'b1, m});
  endtask

  task automatic req(int ch, logic [7:0] cmd, logic [1:0] fl, logic fwd);
    xj     <= {fwd, 2'(ch), cmd};
    no_fwd <= !fwd;
    xp = xs();
    wr(ra(80 + 2 * ch, 1), xp);
    wr(ra(80 + 2 * ch, 0), {22'h0, fl, cmd});
  endtask

  task automatic wait_rsp();
    for (int i = 0; i < 300 && rv !== 1'b1; i++) @(posedge pclk);
    if (rv !== 1'b1) fail("no answer from link");
    repeat (2) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      n_tests++;
      if (q.size() == 0) fail("unexpected apb access");
      else if ((({pslverr, prdata} ^ q[0][65:33]) & q[0][32:0]) !== 0)
        fail("apb response");
      if (q.size() != 0) void'(q.pop_front());
    end
    if (hv && hr) begin
      if (no_fwd) fail("job forwarded");
      n_tests++;
      if (xj[10] && {hch, hcmd, hdat} !== {xj[9:0], xp})
        fail("job fields");
      if (pol && hcmd !== (hch == 2'h1 ? CMD_VAR_NEW : CMD_VAR_OLD))
        fail("poll command");
    end
  end

  initial begin
    repeat (60000) @(posedge pclk);
    fail("watchdog expired");
    final_report();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ra(VAR_REC, 1), {24'h0, QC_INIT}, 32'hff);
    n_tests++;
    if (iab !== 5'h00) fail("input area not empty");
    rd(REV_OFS, 32'h05050505, 32'hffffffff);
    rd(12'h010, 32'h0, 32'hffffffff, 1'b1);
    wr(STAT_OFS, 32'h0, 1'b1);
    $display("done: reset and map");
    d = xs();
    cw  <= 4'hf;
    cfg <= {1'b0, 8'h00, 8'h00, 8'h00, 8'h00, d};
    req(0, 8'h0c, 2'b00, 1'b1);
    rd(STAT_OFS, 32'h10, 32'h10);
    rd(ra(81, 0), {30'h0, PS_BUSY}, 32'h3);
    wr(ra(80, 0), 32'h0c, 1'b1);
    wait_rsp();
    rd(STAT_OFS, 32'h100, 32'h110);
    rd(ra(81, 0), {22'h0, PS_OK}, 32'hff03);
    rd(ra(81, 1), d, 32'hffffffff);
    cw  <= 4'(xs()) | 4'h2;
    cfg <= {1'b0, 8'h11, 8'h00, 8'h00, 8'h00, d};
    req(3, 8'h21, 2'b00, 1'b1);
    wait_rsp();
    cfg <= {1'b0, 8'h22, 8'h00, 8'h00, 8'h00, d};
    req(3, 8'h22, 2'b00, 1'b1);
    wait_rsp();
    rd(ra(87, 0), {16'h0, 8'h22, 6'h0, PS_OK}, 32'hff03);
    req(1, 8'h0d, 2'b10, 1'b0);
    repeat (10) @(posedge pclk);
    rd(ra(83, 0), {16'h0, ERR_INTERP, 6'h0, PS_ERR}, 32'hff03);
    rd(ra(82, 0), {22'h0, 2'b10, 8'h0d}, 32'hffffffff);
    $display("done: mailbox");
    req(2, 8'h0e, 2'b01, 1'b1);
    wait_rsp();
    rd(STAT_OFS, 32'h6, 32'h7);
    req(3, 8'h0e, 2'b00, 1'b0);
    repeat (10) @(posedge pclk);
    rd(ra(87, 0), {16'h0, ERR_RESERVED, 6'h0, PS_ERR}, 32'hff03);
    repeat (6000) @(posedge pclk);
    req(2, 8'h0f, 2'b01, 1'b1);
    wait_rsp();
    repeat (3000) @(posedge pclk);
    rd(STAT_OFS, 32'h4, 32'h4);
    repeat (6000) @(posedge pclk);
    rd(STAT_OFS, 32'h0, 32'h4);
    req(2, 8'h0f, 2'b01, 1'b1);
    wait_rsp();
    req(2, 8'h10, 2'b00, 1'b1);
    wait_rsp();
    rd(STAT_OFS, 32'h0, 32'h4);
    $display("done: reservation");
    xj <= 11'h0;
    cw <= 4'h2;
    wr(ra(MAP_REC, 0), 32'h80);
    n_tests++;
    if (iab !== IN_AREA_BYTES) fail("input area size");
    wr(REV_OFS, 32'h05050705);
    pol <= 1'b1;
    wr(CTRL_OFS, 32'h1);
    for (int k = 0; k < 5; k++) begin
      d = xs();
      cfg <= {qtab[k][24], qtab[k][23:16], 8'h00, qtab[k][15:8], 8'h00, d};
      h = hits;
      for (int i = 0; i < 3000 && 8'(hits - h) < 8'd2; i++) @(posedge pclk);
      if (8'(hits - h) < 8'd2) fail("polling stalled");
      rd(ra(VAR_REC, 1), {24'h0, qtab[k][7:0]}, 32'hff);
      rd(IN_OFS + 12'h010, {24'h0, qtab[k][7:0]}, 32'hff);
      if (k == 0) rd(ra(VAR_REC, 0), d, 32'hffffffff);
      if (k == 0) rd(IN_OFS, d, 32'hffffffff);
    end
    pol <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    $display("done: polling");
    final_report();
  end
endmodule
`default_nettype wire
